// ### bsm_pkg.sv
// bsm_pkg: constants for the boot strap mode select block
// assumes a single 20 MHz clock domain and a plain register port
package bsm_pkg;

	// ******************************************
	// strap codes
	// ******************************************
	localparam logic [2:0] BSM_SERIAL_LOAD_CODE   = 3'h4;
	localparam logic [2:0] BSM_RUN_TWO_WIRE_CODE  = 3'h1;
	localparam logic [2:0] BSM_RUN_FOUR_WIRE_CODE = 3'h0;
	localparam logic [2:0] BSM_LOAD_OR_RUN_CODE   = 3'h2;
	localparam logic [2:0] BSM_FACTORY_RESTORE_CODE = 3'h3;

	// ******************************************
	// flows and restore choices
	// ******************************************
	typedef enum logic [2:0] {
		BSM_FLOW_RUN4    = 3'h0,
		BSM_FLOW_RUN2    = 3'h1,
		BSM_FLOW_LOAD    = 3'h2,
		BSM_FLOW_RESTORE = 3'h3,
		BSM_FLOW_SENSE   = 3'h4
	} bsm_flow_t;

	localparam logic [1:0] BSM_RESTORE_NONE  = 2'h0;
	localparam logic [1:0] BSM_RESTORE_PARAM = 2'h1;
	localparam logic [1:0] BSM_RESTORE_FULL  = 2'h2;

	typedef enum logic [2:0] {
		BSM_ST_SENSE   = 3'h0,
		BSM_ST_BREAK   = 3'h1,
		BSM_ST_RUN     = 3'h2,
		BSM_ST_LOAD    = 3'h3,
		BSM_ST_RESTORE = 3'h4
	} bsm_state_t;

	// ******************************************
	// register map (byte offsets, compared with reg_addr as they stand)
	// ******************************************
	localparam logic [3:0] BSM_REG_STATUS  = 4'h0;
	localparam logic [3:0] BSM_REG_RESTORE = 4'h4;
	localparam logic [3:0] BSM_REG_TRIGGER = 4'h8;
	localparam logic [1:0] BSM_RESTORE_RST = 2'h0;

	// ******************************************
	// timing
	// ******************************************
	localparam int unsigned BSM_CLK_HZ        = 20000000;
	localparam int unsigned BSM_RESTORE_SEC   = 8;
	localparam int unsigned BSM_RESTORE_CYC   = BSM_RESTORE_SEC * BSM_CLK_HZ;
	localparam int unsigned BSM_BREAK_US      = 100;
	localparam int unsigned BSM_BREAK_CYC     = (BSM_BREAK_US * BSM_CLK_HZ) / 1000000;
	localparam int unsigned BSM_SETTLE_CYC    = 16;

endpackage : bsm_pkg

// ### bsm_boot_strap_mode_select.sv
// bsm_boot_strap_mode_select: strap sensing, boot flow choice, factory restore sequencing
// assumes straps have board pulls, a flash engine performing restore steps,
// and a restore progress flag kept in nonvolatile storage outside this block
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module bsm_boot_strap_mode_select
	import bsm_pkg::*;
#(
	parameter int unsigned RESTORE_CYC = BSM_RESTORE_CYC,
	parameter int unsigned BREAK_CYC   = BSM_BREAK_CYC
) (
	input  wire logic        clock,
	input  wire logic        arst_n,
	// straps and pins
	input  wire logic [2:0]  boot_strap_lines,
	output logic [2:0]       boot_strap_pull_down,
	input  wire logic        uart_rx,
	input  wire logic        restore_pending_in,
	output logic             restore_pending_set,
	output logic             restore_pending_clr,
	// flash restore engine
	output logic             flash_restore_param,
	output logic             flash_restore_image,
	input  wire logic        flash_restore_done,
	output logic             factory_sector_lock,
	// mode outputs
	output logic [2:0]       boot_code,
	output logic             serial_load_mode,
	output logic             run_mode,
	output logic             debug_two_wire,
	output logic             debug_four_wire,
	output logic             strap2_output_ok,
	output logic             mode_valid,
	// register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic [31:0]      reg_rdata
);

	// ******************************************
	// synchronisers
	// ******************************************
	logic [2:0] strap_s1_q;
	logic [2:0] strap_s2_q;
	logic [2:0] strap_s3_q;
	logic [2:0] rx_sync_q;
	logic [2:0] pend_sync_q;
	logic [2:0] done_sync_q;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			strap_s1_q  <= 3'h0;
			strap_s2_q  <= 3'h0;
			strap_s3_q  <= 3'h0;
			rx_sync_q   <= 3'h7;
			pend_sync_q <= 3'h0;
			done_sync_q <= 3'h0;
		end else begin
			strap_s1_q  <= boot_strap_lines;
			strap_s2_q  <= strap_s1_q;
			strap_s3_q  <= strap_s2_q;
			rx_sync_q   <= {rx_sync_q[1:0], uart_rx};
			pend_sync_q <= {pend_sync_q[1:0], restore_pending_in};
			done_sync_q <= {done_sync_q[1:0], flash_restore_done};
		end
	end

	// internal pulldowns are always engaged on every strap line
	assign boot_strap_pull_down = 3'h7;

	logic strap_stable;
	logic rx_high;
	logic pend_level;
	logic done_level;
	assign strap_stable = (strap_s2_q == strap_s3_q);
	assign rx_high      = rx_sync_q[1] & rx_sync_q[2];
	assign pend_level   = pend_sync_q[1] & pend_sync_q[2];
	assign done_level   = done_sync_q[1] & done_sync_q[2];

	// ******************************************
	// strap sampling window after reset release
	// ******************************************
	logic [4:0] settle_q;
	logic       sensed_q;
	logic [2:0] code_q;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			settle_q <= 5'h0;
		end else if (!sensed_q && strap_stable && settle_q != 5'(BSM_SETTLE_CYC)) begin
			settle_q <= settle_q + 5'h1;
		end else if (!strap_stable) begin
			settle_q <= 5'h0;
		end
	end

	// captured once per reset and held after that; later strap moves are ignored
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sensed_q <= 1'b0;
			code_q   <= BSM_RUN_FOUR_WIRE_CODE;
		end else if (!sensed_q && settle_q == 5'(BSM_SETTLE_CYC)) begin
			sensed_q <= 1'b1;
			code_q   <= strap_s3_q;
		end
	end

	// ******************************************
	// registers
	// ******************************************
	logic [1:0] restore_sel_q;
	logic       sw_trigger_q;
	logic       restore_busy;
	logic       restore_fail_q;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			restore_sel_q <= BSM_RESTORE_RST;
		end else if (reg_write && reg_addr == BSM_REG_RESTORE) begin
			// the encoding 3 is not a valid choice and maps to none
			restore_sel_q <= (reg_wdata[1:0] == 2'h3) ? BSM_RESTORE_NONE
				: reg_wdata[1:0];
		end
	end

	// a none choice must not start the engine and then sit out the timeout
	logic sel_active;
	assign sel_active = restore_sel_q != BSM_RESTORE_NONE;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sw_trigger_q <= 1'b0;
		end else begin
			sw_trigger_q <= reg_write && reg_addr == BSM_REG_TRIGGER && reg_wdata[0]
				&& sensed_q && !restore_busy
				&& sel_active;
		end
	end

	// ******************************************
	// boot flow state machine
	// ******************************************
	bsm_state_t  state_q;
	bsm_state_t  state_d;
	logic [31:0] timer_q;
	logic        break_seen;
	logic        restore_end;

	assign restore_end = done_level || timer_q >= RESTORE_CYC;
	assign restore_busy = state_q == BSM_ST_RESTORE;

	always_comb begin
		state_d = state_q;
		case (state_q)
			BSM_ST_SENSE: begin
				if (sensed_q) begin
					if (pend_level) begin
						state_d = BSM_ST_RESTORE;
					end else begin
						case (code_q)
							BSM_SERIAL_LOAD_CODE:     state_d = BSM_ST_LOAD;
							BSM_LOAD_OR_RUN_CODE:     state_d = BSM_ST_BREAK;
							BSM_FACTORY_RESTORE_CODE: state_d = BSM_ST_RESTORE;
							BSM_RUN_TWO_WIRE_CODE:    state_d = BSM_ST_RUN;
							default:                  state_d = BSM_ST_RUN;
						endcase
					end
				end
			end
			BSM_ST_BREAK: begin
				// break means rx held low; an agreed high on two samples returns to run
				if (rx_high) begin
					state_d = BSM_ST_RUN;
				end else if (break_seen) begin
					state_d = BSM_ST_LOAD;
				end
			end
			BSM_ST_RUN: begin
				if (sw_trigger_q) begin
					state_d = BSM_ST_RESTORE;
				end
			end
			// no exit: only a new strap sampling leaves load mode
			BSM_ST_LOAD: state_d = BSM_ST_LOAD;
			BSM_ST_RESTORE: begin
				if (restore_end) begin
					state_d = BSM_ST_RUN;
				end
			end
			default: state_d = BSM_ST_SENSE;
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= BSM_ST_SENSE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			timer_q <= 32'h0;
		end else if (state_d != state_q) begin
			timer_q <= 32'h0;
		end else if (timer_q != 32'hffffffff) begin
			timer_q <= timer_q + 32'h1;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			restore_fail_q <= 1'b0;
		end else if (restore_busy && !done_level && timer_q >= RESTORE_CYC) begin
			restore_fail_q <= 1'b1;
		end
	end

	// ******************************************
	// uart break detector
	// ******************************************
	logic [31:0] low_run_q;
	logic        rx_low;

	// only an agreed low counts; a lone low sample is not yet a break
	assign rx_low     = !rx_sync_q[1] && !rx_sync_q[2];
	assign break_seen = low_run_q >= BREAK_CYC;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			low_run_q <= 32'h0;
		end else if (state_q != BSM_ST_BREAK || !rx_low) begin
			low_run_q <= 32'h0;
		end else if (low_run_q != 32'hffffffff) begin
			low_run_q <= low_run_q + 32'h1;
		end
	end

	// ******************************************
	// outputs
	// ******************************************
	logic two_wire_q;
	logic restore_param_q;
	logic restore_image_q;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			two_wire_q <= 1'b0;
		end else if (!sensed_q && settle_q == 5'(BSM_SETTLE_CYC)) begin
			// decided at the latch edge so four-wire never shows for a cycle
			two_wire_q <= strap_s3_q == BSM_RUN_TWO_WIRE_CODE;
		end
	end

	// ******************************************
	// restore engine and marker
	// ******************************************

	// strap-driven restore always does the full image; software uses its choice
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			restore_param_q <= 1'b0;
			restore_image_q <= 1'b0;
		end else if (state_d == BSM_ST_RESTORE && state_q != BSM_ST_RESTORE) begin
			if (state_q == BSM_ST_SENSE) begin
				restore_param_q <= 1'b1;
				restore_image_q <= 1'b1;
			end else begin
				restore_param_q <= restore_sel_q != BSM_RESTORE_NONE;
				restore_image_q <= restore_sel_q == BSM_RESTORE_FULL;
			end
		end else if (state_d != BSM_ST_RESTORE) begin
			restore_param_q <= 1'b0;
			restore_image_q <= 1'b0;
		end
	end

	assign flash_restore_param = restore_param_q;
	assign flash_restore_image = restore_image_q;
	// persist a marker before work begins, clear it when the work ends or the timeout expires
	assign restore_pending_set = state_d == BSM_ST_RESTORE && state_q != BSM_ST_RESTORE;
	assign restore_pending_clr = restore_busy && restore_end;
	assign factory_sector_lock = 1'b1;

	// ******************************************
	// mode pins
	// ******************************************

	assign boot_code        = code_q;
	assign serial_load_mode = state_q == BSM_ST_LOAD;
	assign run_mode         = state_q == BSM_ST_RUN;
	assign debug_two_wire   = two_wire_q;
	assign debug_four_wire  = sensed_q && !two_wire_q;
	// only the top strap may be repurposed; low two stay strap/test only
	assign strap2_output_ok = sensed_q;
	assign mode_valid       = sensed_q;

	// ******************************************
	// register read
	// ******************************************
	logic [31:0] status_word;

	// [8] timeout, [7] sensed, [6] state bit0, [5:3] state, [2:0] code
	assign status_word = {
		23'h0,
		restore_fail_q,
		sensed_q,
		state_q[0],
		state_q,
		code_q
	};

	// reads show state only; no path reaches the factory sector
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 32'h0;
		end else if (reg_read) begin
			case (reg_addr)
				BSM_REG_STATUS:  reg_rdata <= status_word;
				BSM_REG_RESTORE: reg_rdata <= {30'h0, restore_sel_q};
				default:         reg_rdata <= 32'h0;
			endcase
		end else begin
			reg_rdata <= 32'h0;
		end
	end

endmodule : bsm_boot_strap_mode_select

// ### bsm_monitor.sv
// bsm_monitor: assertions on the boot strap mode select ports
// assumes one clock domain and an async active low reset
`timescale 1ns/1ps
module bsm_monitor #(
	parameter int unsigned RESTORE_CYC = 1,
	parameter int unsigned BREAK_CYC   = 1
) (
	input wire logic       clock,
	input wire logic       arst_n,
	input wire logic [2:0] boot_strap_pull_down,
	input wire logic       uart_rx,
	input wire logic       restore_pending_set,
	input wire logic       flash_restore_param,
	input wire logic       flash_restore_image,
	input wire logic       factory_sector_lock,
	input wire logic [2:0] boot_code,
	input wire logic       serial_load_mode,
	input wire logic       run_mode,
	input wire logic       debug_two_wire,
	input wire logic       debug_four_wire,
	input wire logic       mode_valid
);
	// ****************
	// properties
	// ****************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	property p_pins; boot_strap_pull_down == 3'h7 && factory_sector_lock; endproperty
	a_pins: assert property (p_pins) else $error("pulls or lock off");
	property p_two; mode_valid |-> debug_two_wire == (boot_code == 3'h1); endproperty
	a_two: assert property (p_two) else $error("two wire debug wrong");
	property p_four; mode_valid |-> debug_four_wire == !debug_two_wire; endproperty
	a_four: assert property (p_four) else $error("four wire debug wrong");
	property p_hold; mode_valid && $past(mode_valid) |-> $stable(boot_code); endproperty
	a_hold: assert property (p_hold) else $error("latched code moved");
	property p_load; serial_load_mode && boot_code == 3'h4 |=> serial_load_mode; endproperty
	a_load: assert property (p_load) else $error("serial load left");
	property p_img; flash_restore_image |-> flash_restore_param; endproperty
	a_img: assert property (p_img) else $error("image without params");
	property p_brk; $rose(serial_load_mode) && boot_code == 3'h2 |-> !$past(uart_rx, 3); endproperty
	a_brk: assert property (p_brk) else $error("load without break");
	property p_rst; restore_pending_set && boot_code == 3'h3 && !run_mode
		|=> flash_restore_image; endproperty
	a_rst: assert property (p_rst) else $error("strap restore not full");
	c_brk: cover property (serial_load_mode && boot_code == 3'h2);
	c_img: cover property (flash_restore_image);
	c_two: cover property (debug_two_wire);
	c_sw: cover property (flash_restore_param && !flash_restore_image);
endmodule : bsm_monitor

bind bsm_boot_strap_mode_select bsm_monitor #(.RESTORE_CYC(RESTORE_CYC), .BREAK_CYC(BREAK_CYC))
	u_mon (.clock(clock), .arst_n(arst_n), .boot_strap_pull_down(boot_strap_pull_down),
	.uart_rx(uart_rx), .restore_pending_set(restore_pending_set),
	.flash_restore_param(flash_restore_param), .flash_restore_image(flash_restore_image),
	.factory_sector_lock(factory_sector_lock), .boot_code(boot_code),
	.serial_load_mode(serial_load_mode), .run_mode(run_mode),
	.debug_two_wire(debug_two_wire),
	.debug_four_wire(debug_four_wire), .mode_valid(mode_valid));

// ### bsm_far_model.sv
// bsm_far_model: flash restore engine and nonvolatile restore marker
// assumes restore levels from the block; marker survives block reset
`timescale 1ns/1ps
module bsm_far_model #(
	parameter int DONE_CYC = 40
) (
	input  wire logic clock,
	input  wire logic restore_param,
	input  wire logic restore_image,
	input  wire logic pending_set,
	input  wire logic pending_clr,
	output logic      restore_done = 1'b0,
	output logic      pending_out = 1'b0
);
	// ****************
	// engine and marker
	// ****************
	int n = 0;
	// marker has no reset: it stands for storage that outlives power loss
	always @(posedge clock) begin
		n <= (restore_param || restore_image) ? n + 1 : 0;
		restore_done <= (restore_param || restore_image) && n >= DONE_CYC;
		if (pending_set)
			pending_out <= 1'b1;
		else if (pending_clr)
			pending_out <= 1'b0;
	end
endmodule : bsm_far_model

// ### bsm_tb.sv
// tb: boot strap mode select scenarios, self checking
// assumes bsm_far_model stands in for flash engine and marker
`timescale 1ns/1ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin num_errors++; $display("Error %s exp %0h got %0h", n, e, a); end end
module tb;
	import bsm_pkg::*;
	logic        clock = 0, arst_n = 0, rx = 1, wr = 0, rd = 0;
	logic        pend, pset, pclr, prm, img, done, ld, run, d2, d4, ok, mv;
	logic [2:0]  sl = 3'h0, bc;
	logic [3:0]  ad = 4'h0;
	logic [31:0] wd = 32'h0, rdat, v;
	int          num_errors = 0, samples_checked = 0, cyc = 0;
	// ****************
	// clock, design, far side
	// ****************
	always #25 clock = ~clock;
	bsm_boot_strap_mode_select #(.RESTORE_CYC(200), .BREAK_CYC(20)) uut (
		.clock(clock), .arst_n(arst_n), .boot_strap_lines(sl), .boot_strap_pull_down(),
		.uart_rx(rx), .restore_pending_in(pend), .restore_pending_set(pset),
		.restore_pending_clr(pclr), .flash_restore_param(prm), .flash_restore_image(img),
		.flash_restore_done(done), .factory_sector_lock(), .boot_code(bc),
		.serial_load_mode(ld), .run_mode(run), .debug_two_wire(d2), .debug_four_wire(d4),
		.strap2_output_ok(ok), .mode_valid(mv), .reg_addr(ad), .reg_wdata(wd),
		.reg_write(wr), .reg_read(rd), .reg_rdata(rdat));
	bsm_far_model far (.clock(clock), .restore_param(prm), .restore_image(img),
		.pending_set(pset), .pending_clr(pclr), .restore_done(done), .pending_out(pend));
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_sim
	task automatic boot(input logic [2:0] s, input logic r);
		@(posedge clock);
		arst_n <= 0;
		sl     <= s;
		rx     <= r;
		repeat (2) @(posedge clock);
		arst_n <= 1;
		for (int i = 0; i < 100 && mv !== 1; i++) @(posedge clock);
		#1;
		`CHK("boot", 1'b1, mv)
	endtask : boot
	task automatic go();
		for (int i = 0; i < 400 && run !== 1 && ld !== 1; i++) @(posedge clock);
		#1;
		`CHK("flow", 1'b1, run | ld)
	endtask : go
	task automatic wreg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		ad <= a;
		wd <= d;
		wr <= 1;
		@(posedge clock);
		wr <= 0;
	endtask : wreg
	task automatic rreg(input logic [3:0] a, output logic [31:0] d);
		@(posedge clock);
		ad <= a;
		rd <= 1;
		@(posedge clock);
		rd <= 0;
		#1 d = rdat;
	endtask : rreg
	// ****************
	// scenarios
	// ****************
	task automatic s_modes();
		logic [2:0] c [5] = '{3'h0, 3'h1, 3'h4, 3'h2, 3'h2};
		logic       r [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
		logic [3:0] e [5] = '{4'h9, 4'ha, 4'h5, 4'h9, 4'h5};
		for (int i = 0; i < 5; i++) begin
			boot(c[i], r[i]);
			go();
			`CHK("mode", e[i], {run, ld, d2, d4})
			`CHK("code", c[i], bc)
		end
	endtask : s_modes
	task automatic s_hold();
		boot(3'h4, 1'b1);
		go();
		@(posedge clock);
		sl <= 3'h0;
		repeat (300) @(posedge clock);
		#1;
		`CHK("load", 1'b1, ld)
		`CHK("held", 3'h4, bc)
		`CHK("free", 1'b1, ok)
		rreg(BSM_REG_STATUS, v);
		`CHK("stat", 4'hc, {v[7], v[2:0]})
	endtask : s_hold
	task automatic s_regs();
		boot(3'h0, 1'b1);
		go();
		rreg(BSM_REG_RESTORE, v);
		`CHK("rst", 32'h0, v)
		wreg(BSM_REG_RESTORE, 32'h3);
		rreg(BSM_REG_RESTORE, v);
		`CHK("res3", 32'h0, v)
		rreg(4'hc, v);
		`CHK("gap", 32'h0, v)
		wreg(BSM_REG_TRIGGER, 32'h1);
		repeat (3) @(posedge clock);
		#1;
		`CHK("none", 3'h1, {prm, img, run})
		for (int c = 1; c < 3; c++) begin
			wreg(BSM_REG_RESTORE, 32'(c));
			rreg(BSM_REG_RESTORE, v);
			`CHK("res", 32'(c), v)
			wreg(BSM_REG_TRIGGER, 32'h1);
			repeat (3) @(posedge clock);
			#1;
			`CHK("eng", {1'b1, c == 2}, {prm, img})
			go();
			`CHK("back", 1'b1, run)
		end
		rreg(BSM_REG_STATUS, v);
		`CHK("ok", 5'h0a, {v[8:7], v[5:3]})
	endtask : s_regs
	task automatic s_restore();
		boot(3'h3, 1'b1);
		repeat (5) @(posedge clock);
		#1;
		`CHK("strap", 3'h6, {prm, img, run})
		// power lost mid restore, straps back to default
		boot(3'h0, 1'b1);
		repeat (5) @(posedge clock);
		#1;
		`CHK("resume", 2'h2, {prm, run})
		go();
		`CHK("done", 1'b1, run)
		boot(3'h0, 1'b1);
		go();
		`CHK("clear", 2'h1, {prm, run})
	endtask : s_restore
	initial begin
		s_modes();
		s_hold();
		s_regs();
		s_restore();
		end_sim();
	end
endmodule : tb
